// *** lapc_consts.svh ***
// timing and reset constants of the line activity powerdown control
`ifndef LAPC_CONSTS_SVH
`define LAPC_CONSTS_SVH

`define LAPC_CLK_MHZ 250
`define LAPC_US_PER_S 64'h0000_0000_000F_4240
`define LAPC_INV_US 30
`define LAPC_INV_CYC (`LAPC_INV_US * `LAPC_CLK_MHZ)
`define LAPC_VALID_US 1
`define LAPC_VALID_CYC (`LAPC_VALID_US * `LAPC_CLK_MHZ)
`define LAPC_RAMP_US 100
`define LAPC_RAMP_CYC (`LAPC_RAMP_US * `LAPC_CLK_MHZ)
`define LAPC_INACT_S 30
`define LAPC_INACT_W 36
`define LAPC_INACT_CYC (64'(`LAPC_INACT_S) * 64'(`LAPC_CLK_MHZ) * `LAPC_US_PER_S)
`define LAPC_N_TX 2
`define LAPC_N_RX 2
`define LAPC_RST_INV_N 1'b0
`define LAPC_RST_EXPIRED 1'b0
`define LAPC_RST_PRIMED 1'b0
`define LAPC_PRIMED 1'b1

`endif

// *** lapc_edge_det.sv ***
// transition detector over a vector of logic and line inputs
`timescale 1ns/10ps
`default_nettype none
`include "lapc_consts.svh"

module lapc_edge_det #(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [W-1:0] sig_in,
  output logic edge_any
);
  import lapc_pkg::*;

  typedef struct packed {
    logic primed;
    logic [W-1:0] prev;
  } lapc_ed_st_s;

  lapc_ed_st_s st_ff;
  lapc_ed_st_s nxt_st;
  logic [W-1:0] edge_v;

  if (W < 1) begin : g_chk
    $error("lapc_edge_det needs at least one input");
  end

  // per-bit change against last sample
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign edge_v[i] = st_ff.primed & (sig_in[i] ^ st_ff.prev[i]);
  end

  assign edge_any = |edge_v;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = sig_in;
    nxt_st.primed = `LAPC_PRIMED;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule // lapc_edge_det
`default_nettype wire

// *** lapc_peer.sv ***
// remote line peripheral model: drives receiver data and levels
`timescale 1ns/10ps
`default_nettype none
module lapc_peer (
  input wire logic clk_sys,
  input wire logic attach,
  input wire logic tog,
  output logic [1:0] rx_in,
  output logic [1:0] rx_level_valid
);
  initial begin
    rx_in = 2'h0;
    rx_level_valid = 2'h3;
  end
  always @(posedge clk_sys) begin
    rx_level_valid <= {2{attach}};
    rx_in <= attach ? rx_in ^ {1'b0, tog} : 2'h0;
  end
endmodule // lapc_peer
`default_nettype wire

// *** lapc_pkg.sv ***
// types shared by the line activity powerdown control
package lapc_pkg;

  typedef enum logic [1:0] {
    LAPC_PS_DOWN,
    LAPC_PS_RAMP,
    LAPC_PS_ON
  } lapc_pwr_e;

  typedef struct packed {
    logic keep_awake_in;
    logic manual_shutdown_n;
  } lapc_ctrl_s;

  typedef struct packed {
    logic charge_pump_on;
    logic tx_active;
    logic line_invalid_n;
  } lapc_stat_s;

endpackage

// *** lapc_top.sv ***
// line activity detector and inactivity powerdown control
// Function
// - indicator low after all receivers invalid too long
// - indicator high within 1us of valid level
// - detector runs in every power mode
// - floating grounded inputs count as invalid
// - thirty idle seconds power pump and drivers down
// - any input transition wakes the device
// - auto powerdown only with awake low, shutdown high
// - awake disables auto; shutdown low forces down
// - timer stays expired after any powerdown entry
// - indicator alone never changes power state
// - recovery to working drivers takes about 100us
// - detach with shutdown wiring holds device down
// - powerdown tristates drivers, receivers stay active
// - stay powered thirty seconds after awake falls
`timescale 1ns/10ps
`default_nettype none
`include "lapc_consts.svh"

module lapc_top #(
  parameter int N_TX = `LAPC_N_TX,
  parameter int N_RX = `LAPC_N_RX,
  parameter int INV_CYC = `LAPC_INV_CYC,
  parameter int RAMP_CYC = `LAPC_RAMP_CYC,
  parameter logic [`LAPC_INACT_W-1:0] INACT_CYC =
    `LAPC_INACT_W'(`LAPC_INACT_CYC)
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire lapc_pkg::lapc_ctrl_s ctrl,
  input wire logic [N_TX-1:0] tx_in,
  input wire logic [N_RX-1:0] rx_in,
  input wire logic [N_RX-1:0] rx_level_valid,
  output logic [N_TX-1:0] tx_out,
  output logic [N_TX-1:0] tx_oe,
  output logic [N_RX-1:0] rx_out,
  output lapc_pkg::lapc_stat_s stat
);
  import lapc_pkg::*;

  localparam int IW = $clog2(INV_CYC + 1);
  localparam int RW = $clog2(RAMP_CYC + 1);
  localparam int VALID_CYC = `LAPC_VALID_CYC;

  typedef struct packed {
    lapc_pwr_e pstate;
    logic [`LAPC_INACT_W-1:0] inact_cnt;
    logic expired;
    logic [IW-1:0] inv_cnt;
    logic inv_n;
    logic [RW-1:0] ramp_cnt;
    logic ka_prev;
    logic [N_TX-1:0] tx_q;
    logic [N_RX-1:0] rx_q;
  } lapc_top_st_s;

  lapc_top_st_s st_ff;
  lapc_top_st_s nxt_st;
  logic any_edge;
  logic any_valid;
  logic power_req;
  logic ka;
  logic sd_n;

  if (N_TX < 1 || N_RX < 1) begin : g_chk_n
    $error("lapc_top needs at least one driver and one receiver");
  end
  if (INV_CYC < 1 || RAMP_CYC < 1 || INACT_CYC < 2) begin : g_chk_t
    $error("lapc_top timing counts too small");
  end
  if (VALID_CYC < 1) begin : g_chk_v
    $error("lapc_top clock too slow for valid response");
  end

  assign ka = ctrl.keep_awake_in;
  assign sd_n = ctrl.manual_shutdown_n;

  lapc_edge_det #(
    .W(N_TX + N_RX)
  ) u_edge (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .sig_in({tx_in, rx_in}),
    .edge_any(any_edge)
  );

  // grounded floating inputs read as 0 and so invalid
  assign any_valid = |rx_level_valid;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ka_prev = ka;
    nxt_st.tx_q = tx_in;
    // receivers pass data in every mode
    nxt_st.rx_q = rx_in;

    // line level detector, independent of power state
    if (any_valid) begin
      nxt_st.inv_cnt = '0;
      nxt_st.inv_n = 1'b1;
    end else if (st_ff.inv_cnt != IW'(INV_CYC)) begin
      nxt_st.inv_cnt = IW'(st_ff.inv_cnt + 1'b1);
    end else begin
      nxt_st.inv_n = 1'b0;
    end

    // inactivity timer; indicator is not an input here
    if (!sd_n) begin
      nxt_st.expired = 1'b1;
      nxt_st.inact_cnt = '0;
    end else if (ka || any_edge) begin
      // awake high holds count at zero, so its fall starts a full count
      nxt_st.expired = 1'b0;
      nxt_st.inact_cnt = '0;
    end else if (!st_ff.expired) begin
      if (st_ff.inact_cnt == INACT_CYC - 1'b1) begin
        nxt_st.expired = 1'b1;
        nxt_st.inact_cnt = '0;
      end else begin
        nxt_st.inact_cnt = `LAPC_INACT_W'(st_ff.inact_cnt + 1'b1);
      end
    end
    // expired holds until awake or a transition clears it

    power_req = sd_n & (ka | ~nxt_st.expired);

    unique case (st_ff.pstate)
      LAPC_PS_DOWN: begin
        if (power_req) begin
          nxt_st.pstate = LAPC_PS_RAMP;
          nxt_st.ramp_cnt = '0;
        end
      end
      LAPC_PS_RAMP: begin
        if (!power_req) begin
          nxt_st.pstate = LAPC_PS_DOWN;
        end else if (st_ff.ramp_cnt == RW'(RAMP_CYC - 1)) begin
          nxt_st.pstate = LAPC_PS_ON;
        end else begin
          nxt_st.ramp_cnt = RW'(st_ff.ramp_cnt + 1'b1);
        end
      end
      LAPC_PS_ON: begin
        if (!power_req) begin
          nxt_st.pstate = LAPC_PS_DOWN;
        end
      end
      default: begin
        nxt_st.pstate = LAPC_PS_DOWN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_ff.pstate <= LAPC_PS_RAMP;
      st_ff.inact_cnt <= '0;
      st_ff.expired <= `LAPC_RST_EXPIRED;
      st_ff.inv_cnt <= IW'(INV_CYC);
      st_ff.inv_n <= `LAPC_RST_INV_N;
      st_ff.ramp_cnt <= '0;
      st_ff.ka_prev <= 1'b0;
      st_ff.tx_q <= '0;
      st_ff.rx_q <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // drivers tristate unless powered and recovered
  assign tx_oe = {N_TX{st_ff.pstate == LAPC_PS_ON}};
  assign tx_out = st_ff.tx_q;
  assign rx_out = st_ff.rx_q;
  assign stat.charge_pump_on = (st_ff.pstate != LAPC_PS_DOWN);
  assign stat.tx_active = (st_ff.pstate == LAPC_PS_ON);
  assign stat.line_invalid_n = st_ff.inv_n;

  // helper: run of consecutive all-invalid cycles
  logic [IW:0] hlp_inv_run;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      hlp_inv_run <= '0;
    end else if (any_valid) begin
      hlp_inv_run <= '0;
    end else if (hlp_inv_run != (IW + 1)'(INV_CYC + 1)) begin
      hlp_inv_run <= (IW + 1)'(hlp_inv_run + 1'b1);
    end
  end

  // helper: cycles spent recovering before drivers enable
  logic [RW:0] hlp_ramp_run;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      hlp_ramp_run <= '0;
    end else if (st_ff.pstate == LAPC_PS_DOWN) begin
      hlp_ramp_run <= '0;
    end else if (st_ff.pstate == LAPC_PS_RAMP) begin
      hlp_ramp_run <= (RW + 1)'(hlp_ramp_run + 1'b1);
    end
  end

  a_invalid_after_run: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $fell(stat.line_invalid_n) |-> (hlp_inv_run > (IW + 1)'(INV_CYC))
  ) else $error("indicator fell before invalid run elapsed");

  a_valid_fast_high: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    any_valid |=> stat.line_invalid_n
  ) else $error("indicator not high after valid level");

  a_detect_in_down: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (!sd_n && !any_valid) [*2] ##1 !any_valid [*8]
    |-> $stable(stat.line_invalid_n) || !stat.line_invalid_n
  ) else $error("indicator rose without valid level in powerdown");

  a_grounded_no_rise: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !any_valid |=> !$rose(stat.line_invalid_n)
  ) else $error("indicator rose on grounded inputs");

  a_idle_expiry_down: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (sd_n && !ka && !any_edge && !st_ff.expired &&
     st_ff.inact_cnt == INACT_CYC - 1'b1)
    |=> !stat.charge_pump_on && tx_oe == '0
  ) else $error("no powerdown at end of idle count");

  a_edge_wakes: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (any_edge && sd_n) |=> stat.charge_pump_on && st_ff.inact_cnt == '0
  ) else $error("transition did not wake or restart count");

  a_shutdown_forces: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !sd_n |=> !stat.charge_pump_on && st_ff.expired
  ) else $error("shutdown low did not force powerdown");

  a_awake_holds_on: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ka && sd_n) |=> stat.charge_pump_on && !st_ff.expired
  ) else $error("keep awake did not hold power on");

  a_stays_expired: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (!stat.charge_pump_on && !ka && !any_edge) |=> !stat.charge_pump_on
  ) else $error("left powerdown without wake cause");

  a_invalid_no_power: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ($changed(stat.line_invalid_n) && sd_n && !ka && !any_edge &&
     $past(sd_n) && !$past(ka) && !$past(any_edge))
    |-> $stable(st_ff.expired) || st_ff.expired
  ) else $error("indicator change moved power state");

  a_ramp_length: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $rose(stat.tx_active) |-> hlp_ramp_run == (RW + 1)'(RAMP_CYC)
  ) else $error("drivers enabled before recovery time");

  a_down_tristate: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !stat.charge_pump_on |-> tx_oe == '0 ##1 rx_out == $past(rx_in)
  ) else $error("drivers active or receivers stalled in powerdown");

  a_awake_fall_hold: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ($fell(ka) && sd_n && $past(sd_n)) |->
    (sd_n -> stat.charge_pump_on) [*8]
  ) else $error("powered down soon after keep awake fell");

endmodule // lapc_top
`default_nettype wire

// *** test_lapc_top.sv ***
// self-checking bench for the line activity powerdown control
`timescale 1ns/10ps
`default_nettype none
module test_lapc_top;
  import lapc_pkg::*;
  localparam int INV = 20;
  localparam int RAMP = 10;
  localparam int INACT = 50;
  logic clk_sys, nrst, attach, tog, wire_ind, wire_sd;
  lapc_ctrl_s ctrl_drv, ctrl;
  logic [1:0] tx_in, tx_out, tx_oe, rx_in, rx_out, rx_ok;
  lapc_stat_s stat;
  int err_count, n_tests, n;
  assign ctrl = wire_ind ? lapc_ctrl_s'({2{stat.line_invalid_n}}) :
    wire_sd ? lapc_ctrl_s'({1'b0, stat.line_invalid_n}) : ctrl_drv;
  lapc_top #(.INV_CYC(INV), .RAMP_CYC(RAMP), .INACT_CYC(36'(INACT))) u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .ctrl(ctrl), .tx_in(tx_in),
    .rx_in(rx_in), .rx_level_valid(rx_ok), .tx_out(tx_out),
    .tx_oe(tx_oe), .rx_out(rx_out), .stat(stat));
  lapc_peer u_peer (.clk_sys(clk_sys), .attach(attach), .tog(tog),
    .rx_in(rx_in), .rx_level_valid(rx_ok));
  task automatic chk(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi,
    input string m);
    chk(v >= lo && v <= hi, 1'b1, m);
  endtask
  function automatic logic get(input int s);
    case (s)
      0: return stat.charge_pump_on;
      1: return stat.tx_active;
      default: return stat.line_invalid_n;
    endcase
  endfunction
  task automatic wt(input int s, input logic v, input int lim);
    n = 0;
    while (get(s) !== v && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic toggle;
    @(posedge clk_sys);
    tog <= 1'b1;
    @(posedge clk_sys);
    tog <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic setc(input logic ka, input logic sd);
    @(posedge clk_sys);
    ctrl_drv <= '{ka, sd};
    @(negedge clk_sys);
  endtask
  task automatic cable(input logic a, input int lo, input int hi);
    @(posedge clk_sys);
    attach <= a;
    @(negedge clk_sys);
    wt(2, a, hi + 4);
    chk_rng(n, lo, hi, "indicator timing");
  endtask
  task automatic t_level;
    setc(1'b1, 1'b1);
    cable(1'b0, INV + 1, INV + 5);
    chk(stat.tx_active, 1'b1, "power moved by indicator");
    cable(1'b1, 1, 4);
    $display("level test done");
  endtask
  task automatic t_auto;
    setc(1'b0, 1'b1);
    toggle();
    repeat (INACT - 10) @(negedge clk_sys);
    @(posedge clk_sys);
    tx_in <= ~tx_in;
    repeat (2) @(negedge clk_sys);
    chk(tx_out[0], tx_in[0], "tx copy");
    wt(0, 1'b0, INACT + 10);
    chk_rng(n, INACT - 4, INACT + 4, "auto down time");
    chk(tx_oe[0] | tx_oe[1], 1'b0, "drivers left on");
    toggle();
    wt(0, 1'b1, 6);
    chk_rng(n, 0, 4, "wake");
    wt(1, 1'b1, RAMP + 8);
    chk_rng(n, RAMP - 2, RAMP + 4, "recovery");
    $display("auto test done");
  endtask
  task automatic t_keep;
    setc(1'b1, 1'b1);
    repeat (INACT + 10) @(negedge clk_sys);
    chk(stat.charge_pump_on, 1'b1, "keep awake");
    setc(1'b0, 1'b1);
    repeat (INACT - 4) @(negedge clk_sys);
    chk(stat.charge_pump_on, 1'b1, "early down");
    wt(0, 1'b0, 12);
    chk_rng(n, 1, 9, "late down");
    $display("keep test done");
  endtask
  task automatic t_manual;
    setc(1'b1, 1'b0);
    wt(0, 1'b0, 4);
    chk_rng(n, 0, 2, "manual down");
    toggle();
    @(negedge clk_sys);
    chk(stat.charge_pump_on, 1'b0, "woke in shutdown");
    chk(rx_out[0], rx_in[0], "rx copy");
    cable(1'b0, INV + 1, INV + 5);
    cable(1'b1, 1, 4);
    setc(1'b0, 1'b1);
    repeat (5) @(negedge clk_sys);
    chk(stat.charge_pump_on, 1'b0, "timer not held");
    toggle();
    wt(0, 1'b1, 6);
    chk_rng(n, 0, 4, "edge wake");
    setc(1'b0, 1'b0);
    setc(1'b0, 1'b1);
    repeat (5) @(negedge clk_sys);
    chk(stat.charge_pump_on, 1'b0, "timer not held");
    setc(1'b1, 1'b1);
    wt(0, 1'b1, 6);
    chk_rng(n, 0, 4, "awake wake");
    $display("manual test done");
  endtask
  task automatic t_wire;
    @(posedge clk_sys);
    wire_ind <= 1'b1;
    cable(1'b0, INV + 1, INV + 5);
    wt(0, 1'b0, 4);
    chk_rng(n, 0, 3, "cable down");
    cable(1'b1, 1, 4);
    wt(0, 1'b1, 4);
    chk_rng(n, 0, 3, "cable up");
    $display("wired test done");
  endtask
  task automatic t_hybrid;
    @(posedge clk_sys);
    wire_ind <= 1'b0;
    wire_sd <= 1'b1;
    cable(1'b0, INV + 1, INV + 5);
    wt(0, 1'b0, 4);
    chk_rng(n, 0, 3, "detach down");
    cable(1'b1, 1, 4);
    repeat (5) @(negedge clk_sys);
    chk(stat.charge_pump_on, 1'b0, "woke without transition");
    toggle();
    wt(0, 1'b1, 6);
    chk_rng(n, 0, 4, "attach edge wake");
    $display("hybrid test done");
  endtask
  task automatic complete_run;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    err_count++;
    complete_run();
  end
  initial begin
    nrst = 1'b0;
    attach = 1'b1;
    tog = 1'b0;
    wire_ind = 1'b0;
    wire_sd = 1'b0;
    tx_in = 2'h0;
    ctrl_drv = '{1'b1, 1'b1};
    err_count = 0;
    n_tests = 0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    wt(1, 1'b1, RAMP + 8);
    t_level();
    t_auto();
    t_keep();
    t_manual();
    t_wire();
    t_hybrid();
    complete_run();
  end
endmodule // test_lapc_top
`default_nettype wire
